// File: hw/mia_defines.svh
`ifndef MIA_DEFINES_SVH
`define MIA_DEFINES_SVH

// Host I/O addresses
`define MIA_ARB_OFS 16'h0130
`define MIA_OPT_OFS 16'h0096

// Option-select register layout
`define MIA_OPT_EN_BIT 3
`define MIA_OPT_SEL_MSB 2
`define MIA_OPT_SEL_LSB 0
`define MIA_OPT_RST 8'h00

// Channel and request line counts
`define MIA_NPORT 16
`define MIA_NIRQ 8

// Idle value of the arbitration word: nothing pending
`define MIA_ARB_IDLE 16'h8000

`endif

// File: hw/mia_pkg.sv
package mia_pkg;

   // Interrupt type code reported by one serial channel
   typedef logic [2:0] mia_itype_t;

   // Interrupt type of all sixteen channels, port 0 in the low slot
   typedef mia_itype_t [15:0] mia_itype_vec_t;

   // Arbitration word as the host reads it
   typedef struct packed {
      logic none;          // Set when no port is pending
      logic [4:0] rsv;     // Reads as zero
      logic [2:0] adapter; // Adapter identification
      logic [3:0] port;    // Winning port
      mia_itype_t itype;   // Interrupt type of the winning port
   } mia_arb_s;

   // One host I/O cycle
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } mia_io_req_s;

endpackage

// File: hw/mia_prio_enc.sv
`timescale 1ns/1ps
// Fixed-priority pick: the lowest set index wins
module mia_prio_enc
   import mia_pkg::*;
(
   // Pending requests
   input wire logic [15:0] pend,
   // Result
   output logic found,
   output logic [3:0] idx
);

   // Scan from the top down so the lowest index is written last and wins
   always_comb begin
      found = 1'b0;
      idx = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (pend[i]) begin
            found = 1'b1;
            idx = 4'(i);
         end
      end
   end

endmodule

// File: hw/mia_irq_arbiter.sv
`timescale 1ns/1ps
`include "mia_defines.svh"
module mia_irq_arbiter
   import mia_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Host I/O cycle, same clock as the adapter
   input mia_pkg::mia_io_req_s io_req,
   input wire logic setup_cycle,
   output logic [15:0] io_rdata,
   output logic io_rdata_vld,
   output logic io_rdata_oe,
   // Serial channel interrupt sources, asynchronous pins
   input wire logic [15:0] port_irq,
   input mia_pkg::mia_itype_vec_t port_itype,
   // Adapter identity straps
   input wire logic [2:0] adapter_id,
   input wire logic chain_tail,
   // Sharing chain between adapters
   input wire logic chain_busy_in,
   output logic chain_busy_out,
   // Open-collector request lines, index 0..7 = levels 3,5,9,10,11,12,14,15
   output logic [7:0] irq_o,
   output logic [7:0] irq_oe
);
   import mia_pkg::*;

   // Decode a three-bit level select into a one-hot line mask
   function automatic logic [7:0] sel_onehot(input logic [2:0] sel);
      sel_onehot = 8'h01 << sel;
   endfunction

   // Two-stage synchronisers for pin inputs
   logic [15:0] irq_s1_r, irq_s2_r;
   mia_itype_vec_t type_s1_r, type_s2_r;
   logic [2:0] id_s1_r, id_s2_r;
   logic tail_s1_r, tail_s2_r;
   logic busy_s1_r, busy_s2_r;

   // Strapped identity, captured while reset is held
   logic [2:0] adapter_id_r;
   logic tail_r;

   // Option-select register written only in the setup cycle
   logic [7:0] opt_r, opt_nxt;

   // Arbitration state
   mia_arb_s arb_r, arb_nxt;
   logic [15:0] rdata_r;
   logic rdata_vld_r;
   logic rdata_oe_r;
   logic [7:0] irq_oe_r;
   logic busy_out_r;

   // Priority encoder outputs
   logic win_found;
   logic [3:0] win_idx;

   // Address decode
   wire arb_hit = io_req.addr == `MIA_ARB_OFS;
   wire opt_hit = io_req.addr == `MIA_OPT_OFS;
   wire arb_rd = io_req.rd && arb_hit;
   wire opt_wr = io_req.wr && opt_hit && setup_cycle;
   wire opt_en = opt_r[`MIA_OPT_EN_BIT];
   wire [2:0] opt_sel = opt_r[`MIA_OPT_SEL_MSB:`MIA_OPT_SEL_LSB];
   // Option value as it will stand after this edge, for the line drive
   wire opt_nxt_en = opt_nxt[`MIA_OPT_EN_BIT];
   wire [2:0] opt_nxt_sel = opt_nxt[`MIA_OPT_SEL_MSB:`MIA_OPT_SEL_LSB];

   // This adapter answers the shared read when nobody ahead is pending,
   // and either it is pending or it is the last adapter in the chain
   wire may_answer = !busy_s2_r && (win_found || tail_r);

   // Synchronisers carry no reset; their first stage feeds only the second
   always_ff @(posedge clk) begin
      irq_s1_r <= port_irq;
      irq_s2_r <= irq_s1_r;
      type_s1_r <= port_itype;
      type_s2_r <= type_s1_r;
      id_s1_r <= adapter_id;
      id_s2_r <= id_s1_r;
      tail_s1_r <= chain_tail;
      tail_s2_r <= tail_s1_r;
      busy_s1_r <= chain_busy_in;
      busy_s2_r <= busy_s1_r;
   end

   // Straps are sampled during reset and frozen after its release,
   // so a late-settling strap cannot change identity mid-operation
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         adapter_id_r <= id_s2_r;
         tail_r <= tail_s2_r;
      end
   end

   // Fixed-priority winner among the pending channels
   mia_prio_enc u_prio (
      .pend(irq_s2_r),
      .found(win_found),
      .idx(win_idx)
   );

   // Next option register value: writes outside setup are ignored
   always_comb begin
      opt_nxt = opt_r;
      if (opt_wr) begin
         opt_nxt = io_req.wdata;
      end
   end

   // Next arbitration word, rebuilt every cycle from the winner
   always_comb begin
      arb_nxt = mia_arb_s'(`MIA_ARB_IDLE);
      arb_nxt.adapter = adapter_id_r;
      if (win_found) begin
         // Winner's identity and type, all in one word
         arb_nxt.none = 1'b0;
         arb_nxt.port = win_idx;
         arb_nxt.itype = type_s2_r[win_idx];
      end
   end

   // Option register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         opt_r <= `MIA_OPT_RST;
      end else begin
         opt_r <= opt_nxt;
      end
   end

   // Arbitration register tracks the current winner
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arb_r <= mia_arb_s'(`MIA_ARB_IDLE);
      end else begin
         arb_r <= arb_nxt;
      end
   end

   // Read path: a read of the arbitration address returns the whole word
   // one cycle later; data holds until the next read
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= 16'h0000;
         rdata_vld_r <= 1'b0;
         rdata_oe_r <= 1'b0;
      end else begin
         rdata_vld_r <= arb_rd;
         rdata_oe_r <= arb_rd && may_answer;
         if (arb_rd) begin
            rdata_r <= arb_r;
         end
      end
   end

   // Request drive: only the selected line, only while something is pending.
   // Driving from the next word and next option keeps the line in step with both
   // registers, so a reselection never leaves the old line pulled for a cycle.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_oe_r <= 8'h00;
         busy_out_r <= 1'b0;
      end else begin
         irq_oe_r <= (opt_nxt_en && !arb_nxt.none) ? sel_onehot(opt_nxt_sel) : 8'h00;
         busy_out_r <= busy_s2_r || win_found;
      end
   end

   // Open collector: the level driven is always low, enable carries the request
   assign irq_o = 8'h00;
   assign irq_oe = irq_oe_r;
   assign io_rdata = rdata_r;
   assign io_rdata_vld = rdata_vld_r;
   assign io_rdata_oe = rdata_oe_r;
   assign chain_busy_out = busy_out_r;

   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // At most one request line is ever driven
   property p_one_line;
      $onehot0(irq_oe);
   endproperty
   a_one_line: assert property (p_one_line) else $error("more than one request line driven");

   // A driven line is the selected one
   property p_sel_line;
      irq_oe != 8'h00 |-> irq_oe == sel_onehot(opt_sel) && opt_en;
   endproperty
   a_sel_line: assert property (p_sel_line) else $error("driven line differs from selection");

   // Lines only ever pull low
   property p_low_only;
      irq_o == 8'h00;
   endproperty
   a_low_only: assert property (p_low_only) else $error("request line driven high");

   // With the line enabled and the option steady, it drives exactly when the word reports a pending port
   property p_drive_pending;
      opt_en && $stable(opt_r) |-> ((irq_oe != 8'h00) == !arb_r.none);
   endproperty
   a_drive_pending: assert property (p_drive_pending) else $error("line and word disagree");

   // Port 0 pending at the sync output wins on the next cycle
   property p_port0_wins;
      irq_s2_r[0] |=> arb_r.port == 4'h0 && !arb_r.none;
   endproperty
   a_port0_wins: assert property (p_port0_wins) else $error("port 0 did not win");

   // No lower-numbered port is pending when the word names a winner
   property p_no_higher;
      !arb_nxt.none |-> (irq_s2_r & ((16'h0001 << arb_nxt.port) - 16'h0001)) == 16'h0000;
   endproperty
   a_no_higher: assert property (p_no_higher) else $error("higher priority port skipped");

   // A read returns the arbitration word of that cycle one cycle later
   property p_read_word;
      logic [15:0] w;
      (arb_rd, w = arb_r) |=> io_rdata_vld && io_rdata == w;
   endproperty
   a_read_word: assert property (p_read_word) else $error("read did not return word");

   // Valid pulses only after a read of the arbitration address
   property p_vld_cause;
      io_rdata_vld |-> $past(arb_rd);
   endproperty
   a_vld_cause: assert property (p_vld_cause) else $error("spurious read valid");

   // Word carries the strapped adapter identity; the reset word is a constant,
   // so the first cycle after release is left out
   property p_adapter_id;
      !$past(sys_rst) |-> arb_r.adapter == adapter_id_r && arb_r.rsv == 5'h00;
   endproperty
   a_adapter_id: assert property (p_adapter_id) else $error("adapter id wrong");

   // Option register moves only on a setup write
   property p_opt_setup;
      !$stable(opt_r) |-> $past(opt_wr);
   endproperty
   a_opt_setup: assert property (p_opt_setup) else $error("option changed outside setup");

   // Busy passes downstream when pending here or upstream
   property p_busy_chain;
      (busy_s2_r || win_found) |=> chain_busy_out;
   endproperty
   a_busy_chain: assert property (p_busy_chain) else $error("busy not forwarded");

   // Main scenarios
   c_two_pending: cover property (irq_s2_r[0] && irq_s2_r[15]);
   c_read_pending: cover property (arb_rd && !arb_r.none);
   c_read_idle: cover property (arb_rd && arb_r.none);
   c_line_drive: cover property (irq_oe != 8'h00);

endmodule

// File: verification/mia_host_model.sv
`timescale 1ns/1ps
// Host side of the adapter: issues I/O cycles on the adapter clock
module mia_host_model (
   // Clock
   input wire logic clk,
   // I/O cycle to the adapter
   output mia_pkg::mia_io_req_s io_req,
   output logic setup_cycle,
   // Read answer
   input wire logic [15:0] io_rdata,
   input wire logic io_rdata_vld,
   input wire logic io_rdata_oe
);
   import mia_pkg::*;

   // Idle bus at time zero
   initial begin
      io_req = '0;
      setup_cycle = 1'b0;
   end

   // Option write; the caller picks the setup flag so that refusals can be tried
   // The host should give every adapter the same level; the bench keeps one adapter
   task automatic opt_write(input logic [7:0] d, input logic setup);
      @(posedge clk);
      #1;
      io_req = '{rd: 1'b0, wr: 1'b1, addr: 16'h0096, wdata: d};
      setup_cycle = setup;
      @(posedge clk);
      #1;
      io_req = '0;
      setup_cycle = 1'b0;
   endtask

   // One read; strobe held until the taking edge, answer sampled right after it
   task automatic io_read(input logic [15:0] a, output logic [15:0] w, output logic v, output logic oe);
      @(posedge clk);
      #1;
      io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1;
      io_req = '0;
      w = io_rdata;
      v = io_rdata_vld;
      oe = io_rdata_oe;
   endtask
endmodule

// File: verification/tb_mia_irq_arbiter.sv
`timescale 1ns/1ps
// Self-checking bench for the interrupt arbiter
module tb_mia_irq_arbiter;
   import mia_pkg::*;

   logic clk;
   logic sys_rst;
   logic [15:0] port_irq;
   mia_itype_vec_t port_itype;
   logic [2:0] adapter_id;
   logic chain_tail;
   logic chain_busy_in;
   mia_io_req_s io_req;
   logic setup_cycle;
   logic [15:0] io_rdata;
   logic io_rdata_vld;
   logic io_rdata_oe;
   logic chain_busy_out;
   logic [7:0] irq_o;
   logic [7:0] irq_oe;
   wire [7:0] irq_line;
   int failures;
   int checks;
   logic [15:0] w;
   logic v;
   logic oe;

   // Pull-up holds every released line high
   assign irq_line = irq_o | ~irq_oe;

   mia_irq_arbiter mia_irq_arbiter_i (.clk(clk), .sys_rst(sys_rst), .io_req(io_req), .setup_cycle(setup_cycle),
      .io_rdata(io_rdata), .io_rdata_vld(io_rdata_vld), .io_rdata_oe(io_rdata_oe), .port_irq(port_irq),
      .port_itype(port_itype), .adapter_id(adapter_id), .chain_tail(chain_tail), .chain_busy_in(chain_busy_in),
      .chain_busy_out(chain_busy_out), .irq_o(irq_o), .irq_oe(irq_oe));

   mia_host_model mia_host_model_i (.clk(clk), .io_req(io_req), .setup_cycle(setup_cycle), .io_rdata(io_rdata),
      .io_rdata_vld(io_rdata_vld), .io_rdata_oe(io_rdata_oe));

   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Compare and count
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Expected arbitration word for one port
   function automatic logic [15:0] word(input int k);
      return {1'b0, 5'h00, adapter_id, k[3:0], port_itype[k]};
   endfunction

   // Let the two sync stages and the register settle
   task automatic settle();
      repeat (5) @(posedge clk);
      #1;
   endtask

   // Idle state after reset and the idle word
   task automatic t_reset();
      chk("irq_oe", 16'h0000, {8'h00, irq_oe});
      chk("busy_out", 16'h0000, {15'h0000, chain_busy_out});
      mia_host_model_i.io_read(16'h0130, w, v, oe);
      chk("idle word", {1'b1, 5'h00, adapter_id, 7'h00}, w);
      chk("vld oe", 16'h0003, {14'h0000, v, oe});
   endtask

   // Write outside setup and read of the option address are both dropped
   task automatic t_refused();
      mia_host_model_i.opt_write(8'h0B, 1'b0);
      port_irq = 16'h0010;
      settle();
      chk("irq_oe off", 16'h0000, {8'h00, irq_oe});
      mia_host_model_i.io_read(16'h0096, w, v, oe);
      chk("opt read vld", 16'h0000, {15'h0000, v});
      mia_host_model_i.io_read(16'h0130, w, v, oe);
      chk("word port 4", word(4), w);
      chk("busy_out", 16'h0001, {15'h0000, chain_busy_out});
   endtask

   // Every selectable line, one at a time, pulled low
   task automatic t_lines();
      for (int i = 0; i < 8; i++) begin
         mia_host_model_i.opt_write(8'h08 | i[7:0], 1'b1);
         settle();
         chk("irq_oe sel", 16'h0001 << i, {8'h00, irq_oe});
         chk("irq_line", {8'h00, ~(8'h01 << i)}, {8'h00, irq_line});
      end
      mia_host_model_i.opt_write(8'h03, 1'b1);
      settle();
      chk("irq_oe disabled", 16'h0000, {8'h00, irq_oe});
   endtask

   // Lowest pending port wins at every position
   task automatic t_prio();
      mia_host_model_i.opt_write(8'h0A, 1'b1);
      for (int k = 0; k < 16; k++) begin
         port_irq = 16'hFFFF << k;
         settle();
         mia_host_model_i.io_read(16'h0130, w, v, oe);
         chk("prio word", word(k), w);
      end
      chk("irq_oe level 9", 16'h0004, {8'h00, irq_oe});
   endtask

   // Nothing pending releases the line
   task automatic t_release();
      port_irq = 16'h0000;
      settle();
      chk("line released", 16'h00FF, {8'h00, irq_line});
      mia_host_model_i.io_read(16'h0130, w, v, oe);
      chk("none word", {1'b1, 5'h00, adapter_id, 7'h00}, w);
   endtask

   // A busy adapter upstream takes the shared data bus
   task automatic t_chain();
      port_irq = 16'h8000;
      chain_busy_in = 1'b1;
      settle();
      mia_host_model_i.io_read(16'h0130, w, v, oe);
      chk("oe yields", 16'h0002, {14'h0000, v, oe});
      chk("word port 15", word(15), w);
      chain_busy_in = 1'b0;
      settle();
      mia_host_model_i.io_read(16'h0130, w, v, oe);
      chk("oe owns", 16'h0003, {14'h0000, v, oe});
   endtask

   // Second reset in mid-run with new straps: option cleared, line released,
   // and a non-tail adapter keeps off the shared data while idle
   task automatic t_rerun();
      port_irq = 16'h0002;
      mia_host_model_i.opt_write(8'h0F, 1'b1);
      settle();
      chk("irq_oe before reset", 16'h0080, {8'h00, irq_oe});
      sys_rst = 1'b1;
      adapter_id = 3'h2;
      chain_tail = 1'b0;
      port_irq = 16'h0000;
      repeat (8) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      chk("irq_oe after reset", 16'h0000, {8'h00, irq_oe});
      chk("rdata after reset", 16'h0000, io_rdata);
      mia_host_model_i.io_read(16'h0130, w, v, oe);
      chk("idle word new id", {1'b1, 5'h00, adapter_id, 7'h00}, w);
      chk("vld oe not tail", 16'h0002, {14'h0000, v, oe});
      port_irq = 16'h0002;
      settle();
      chk("irq_oe option cleared", 16'h0000, {8'h00, irq_oe});
      mia_host_model_i.io_read(16'h0130, w, v, oe);
      chk("word port 1 new id", word(1), w);
      chk("vld oe pending", 16'h0003, {14'h0000, v, oe});
   endtask

   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Main sequence
   initial begin
      failures = 0;
      checks = 0;
      sys_rst = 1'b1;
      port_irq = 16'h0000;
      adapter_id = 3'h5;
      chain_tail = 1'b1;
      chain_busy_in = 1'b0;
      for (int k = 0; k < 16; k++) port_itype[k] = k[2:0] ^ 3'h6;
      repeat (8) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      t_reset();
      t_refused();
      t_lines();
      t_prio();
      t_release();
      t_chain();
      t_rerun();
      close_out();
   end

   // Hang guard, well beyond the few hundred cycles the tests take
   initial begin
      #20000;
      failures++;
      close_out();
   end
endmodule
